/* File: src/rxccf_top.v */
// receive control-cell change detection with per-link result fifos and an axi4-lite register slave
// assumes cells arrive one at a time as 53 byte strobes, first byte flagged by cell_sop, all synchronous to aclk
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "rxccf_consts.vh"

module rxccf_top #(
    parameter LINKS  = 16,
    parameter ADDR_W = 12
) (
    // clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // received cell byte stream
    input  wire              cell_valid,
    input  wire              cell_sop,
    input  wire              cell_ctrl,
    input  wire [3:0]        cell_link,
    input  wire [7:0]        cell_data,
    // axi4-lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // axi4-lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready
);

    localparam CELLS = 53;

    function [9:0] prev_idx;
        input [3:0] link;
        input [5:0] off;
        begin
            prev_idx = link * 10'd53 + {4'h0, off} - 10'd1;
        end
    endfunction

    function [5:0] fifo_idx;
        input [3:0] link;
        input [1:0] ptr;
        begin
            fifo_idx = {link, ptr};
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [15:0] data;
        input [1:0]  strb;
        reg   [15:0] mask;
        begin
            mask    = {{8{strb[1]}}, {8{strb[0]}}};
            merge16 = (old & ~mask) | (data & mask);
        end
    endfunction

    // control registers
    reg  [31:0]              cell_type_reg;
    reg  [15:0]              proc_en_reg;
    reg  [3:0]               status_sel_reg;
    reg  [`RXCCF_DBG_W-1:0]  debug_reg;
    // previous cell per link, result fifo per link
    reg  [7:0]               prev_mem [0:LINKS*CELLS-1];
    reg  [14:0]              fifo_mem [0:LINKS*4-1];
    reg  [1:0]               wptr_reg [0:LINKS-1];
    reg  [1:0]               rptr_reg [0:LINKS-1];
    // cell walk and pending change word
    reg                      in_cell_reg;
    reg  [3:0]               cur_link_reg;
    reg  [5:0]               off_reg;
    reg                      cur_store_reg;
    reg                      cur_cmp_reg;
    reg                      pend_valid_reg;
    reg  [3:0]               pend_link_reg;
    reg  [5:0]               pend_off_reg;
    reg  [7:0]               pend_data_reg;
    reg                      flush_reg;
    // bus slave state
    reg                      aw_got_reg;
    reg                      w_got_reg;
    reg  [ADDR_W-1:0]        awaddr_reg;
    reg  [15:0]              wdata_reg;
    reg  [1:0]               wstrb_reg;

    wire [9:0]               wr_idx = awaddr_reg[ADDR_W-1:2];
    wire [9:0]               rd_idx = s_axi_araddr[ADDR_W-1:2];
    wire                     do_wr  = aw_got_reg & w_got_reg;
    wire                     aw_fire = s_axi_awvalid & s_axi_awready;
    wire                     w_fire  = s_axi_wvalid & s_axi_wready;
    wire                     ar_fire = s_axi_arvalid & s_axi_arready;
    wire                     aw_got_next = do_wr ? 1'b0 : (aw_got_reg | aw_fire);
    wire                     w_got_next  = do_wr ? 1'b0 : (w_got_reg | w_fire);
    wire                     bvalid_next = do_wr | (s_axi_bvalid & ~s_axi_bready);
    wire                     rvalid_next = ar_fire | (s_axi_rvalid & ~s_axi_rready);
    wire [15:0]              adv_vec = (do_wr && wr_idx == `RXCCF_IDX_ADVANCE) ?
                                       (wdata_reg & {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}}) : 16'h0000;

    // byte handling for the cell in flight
    wire                     byte_take = cell_valid & (cell_sop | in_cell_reg);
    wire [3:0]               eff_link  = cell_sop ? cell_link : cur_link_reg;
    wire [5:0]               eff_off   = cell_sop ? 6'd1 : off_reg;
    wire [1:0]               link_mode = cell_type_reg[{cell_link, 1'b0} +: 2];
    wire                     sop_store = (link_mode == `RXCCF_MODE_ALL_CELL) |
                                         ((link_mode == `RXCCF_MODE_CHG_CTRL || link_mode == `RXCCF_MODE_ALL_CTRL)
                                          & cell_ctrl);
    wire                     eff_store = cell_sop ? sop_store : cur_store_reg;
    wire                     eff_cmp   = cell_sop ? (sop_store & proc_en_reg[cell_link]) : cur_cmp_reg;
    // payload-only span skips the five header bytes
    wire                     in_span   = ~debug_reg[`RXCCF_DBG_PAYLOAD] | (eff_off > `RXCCF_HDR_BYTES);
    wire [7:0]               prev_byte = prev_mem[prev_idx(eff_link, eff_off)];
    wire                     diff_now  = byte_take & eff_store & eff_cmp & in_span & (prev_byte != cell_data);
    wire                     cell_end  = byte_take & (eff_off == `RXCCF_CELL_BYTES);
    // a word is pushed when a later difference or the cell's end proves whether it was the last
    wire                     push      = pend_valid_reg & (diff_now | flush_reg);
    wire [14:0]              push_word = {flush_reg, pend_off_reg, pend_data_reg};
    wire [1:0]               push_lvl  = wptr_reg[pend_link_reg] - rptr_reg[pend_link_reg];
    // one slot stays unused so the level fits in two bits; a word arriving on a full fifo is lost
    wire                     push_ok   = push & (push_lvl != 2'd3);

    // one loop variable per process so none is driven from two places
    integer i;
    integer j;
    integer k;

    always @(posedge aclk) begin
        if (!aresetn) begin
            in_cell_reg    <= 1'b0;
            cur_link_reg   <= 4'h0;
            off_reg        <= 6'd0;
            cur_store_reg  <= 1'b0;
            cur_cmp_reg    <= 1'b0;
            pend_valid_reg <= 1'b0;
            pend_link_reg  <= 4'h0;
            pend_off_reg   <= 6'd0;
            pend_data_reg  <= 8'h00;
            flush_reg      <= 1'b0;
            for (i = 0; i < LINKS*CELLS; i = i + 1) begin
                prev_mem[i] <= 8'h00;
            end
        end else begin
            flush_reg <= cell_end;
            if (byte_take) begin
                cur_link_reg  <= eff_link;
                cur_store_reg <= eff_store;
                cur_cmp_reg   <= eff_cmp;
                off_reg       <= eff_off + 6'd1;
                in_cell_reg   <= ~cell_end;
                if (eff_store) begin
                    prev_mem[prev_idx(eff_link, eff_off)] <= cell_data;
                end
            end
            if (diff_now) begin
                pend_valid_reg <= 1'b1;
                pend_link_reg  <= eff_link;
                pend_off_reg   <= eff_off;
                pend_data_reg  <= cell_data;
            end else if (flush_reg) begin
                pend_valid_reg <= 1'b0;
            end
        end
    end

    // result fifos
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (k = 0; k < LINKS; k = k + 1) begin
                wptr_reg[k] <= 2'd0;
                rptr_reg[k] <= 2'd0;
            end
            for (k = 0; k < LINKS*4; k = k + 1) begin
                fifo_mem[k] <= 15'h0000;
            end
        end else begin
            if (push_ok) begin
                fifo_mem[fifo_idx(pend_link_reg, wptr_reg[pend_link_reg])] <= push_word;
                wptr_reg[pend_link_reg] <= wptr_reg[pend_link_reg] + 2'd1;
            end
            for (k = 0; k < LINKS; k = k + 1) begin
                if (adv_vec[k] && wptr_reg[k] != rptr_reg[k]) begin
                    rptr_reg[k] <= rptr_reg[k] + 2'd1;
                end
            end
        end
    end

    // register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            cell_type_reg  <= 32'h00000000;
            proc_en_reg    <= `RXCCF_REG_RESET;
            status_sel_reg <= 4'h0;
            debug_reg      <= 6'h00;
        end else if (do_wr) begin
            case (wr_idx)
                `RXCCF_IDX_TYPE_LO: cell_type_reg[15:0]  <= merge16(cell_type_reg[15:0], wdata_reg, wstrb_reg);
                `RXCCF_IDX_TYPE_HI: cell_type_reg[31:16] <= merge16(cell_type_reg[31:16], wdata_reg, wstrb_reg);
                `RXCCF_IDX_PROC_EN: proc_en_reg <= merge16(proc_en_reg, wdata_reg, wstrb_reg);
                `RXCCF_IDX_STATUS: begin
                    if (wstrb_reg[0]) begin
                        status_sel_reg <= wdata_reg[3:0];
                    end
                end
                `RXCCF_IDX_DEBUG: begin
                    if (wstrb_reg[0]) begin
                        debug_reg <= wdata_reg[`RXCCF_DBG_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // read data, decoded at the address handshake
    reg  [15:0] rd_val;
    reg         rd_hit;
    reg  [3:0]  rl;
    reg  [1:0]  rl_lvl;
    always @* begin
        rd_val = 16'h0000;
        rd_hit = 1'b1;
        rl     = rd_idx[3:0];
        rl_lvl = wptr_reg[rl] - rptr_reg[rl];
        if (rd_idx >= `RXCCF_IDX_RESULT && rd_idx <= `RXCCF_IDX_RESULT_END) begin
            if (rl_lvl == 2'd0) begin
                rd_val = `RXCCF_RESULT_RESET;
            end else begin
                rd_val = {(rl_lvl > 2'd1), fifo_mem[fifo_idx(rl, rptr_reg[rl])]};
            end
        end else begin
            case (rd_idx)
                `RXCCF_IDX_TYPE_LO:  rd_val = cell_type_reg[15:0];
                `RXCCF_IDX_TYPE_HI:  rd_val = cell_type_reg[31:16];
                `RXCCF_IDX_PROC_EN:  rd_val = proc_en_reg;
                `RXCCF_IDX_ADVANCE:  rd_val = 16'h0000;
                `RXCCF_IDX_STATUS:   rd_val = {10'h000, wptr_reg[status_sel_reg] - rptr_reg[status_sel_reg],
                                               wptr_reg[status_sel_reg], rptr_reg[status_sel_reg]};
                `RXCCF_IDX_DEBUG:    rd_val = {10'h000, debug_reg};
                `RXCCF_IDX_NONEMPTY: begin
                    for (j = 0; j < LINKS; j = j + 1) begin
                        rd_val[j] = (wptr_reg[j] != rptr_reg[j]);
                    end
                end
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // axi4-lite handshakes
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            awaddr_reg    <= {ADDR_W{1'b0}};
            wdata_reg     <= 16'h0000;
            wstrb_reg     <= 2'b00;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RXCCF_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RXCCF_RESP_OKAY;
        end else begin
            aw_got_reg    <= aw_got_next;
            w_got_reg     <= w_got_next;
            s_axi_awready <= ~aw_got_next & ~bvalid_next;
            s_axi_wready  <= ~w_got_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_arready <= ~rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (aw_fire) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_reg <= s_axi_wdata[15:0];
                wstrb_reg <= s_axi_wstrb[1:0];
            end
            if (do_wr) begin
                case (wr_idx)
                    `RXCCF_IDX_TYPE_LO, `RXCCF_IDX_TYPE_HI, `RXCCF_IDX_PROC_EN, `RXCCF_IDX_ADVANCE,
                    `RXCCF_IDX_STATUS, `RXCCF_IDX_DEBUG: s_axi_bresp <= `RXCCF_RESP_OKAY;
                    default: s_axi_bresp <= `RXCCF_RESP_SLVERR;
                endcase
            end
            if (ar_fire) begin
                s_axi_rdata <= {16'h0000, rd_val};
                s_axi_rresp <= rd_hit ? `RXCCF_RESP_OKAY : `RXCCF_RESP_SLVERR;
            end
        end
    end

endmodule // rxccf_top

/* File: src/rxccf_consts.vh */
// register indices, field positions, reset values and cell geometry of the change fifo block
// assumes includers map byte address = index * 4 on a 32-bit register bus
`ifndef RXCCF_CONSTS_VH
`define RXCCF_CONSTS_VH
`define RXCCF_IDX_TYPE_LO    10'h100
`define RXCCF_IDX_TYPE_HI    10'h101
`define RXCCF_IDX_PROC_EN    10'h102
`define RXCCF_IDX_ADVANCE    10'h105
`define RXCCF_IDX_STATUS     10'h106
`define RXCCF_IDX_NONEMPTY   10'h107
`define RXCCF_IDX_DEBUG      10'h108
`define RXCCF_IDX_RESULT     10'h140
`define RXCCF_IDX_RESULT_END 10'h14f
`define RXCCF_RESULT_RESET   16'h8000
`define RXCCF_REG_RESET      16'h0000
`define RXCCF_MORE_BIT       15
`define RXCCF_LAST_BIT       14
`define RXCCF_DBG_W          6
`define RXCCF_DBG_PAYLOAD    1
`define RXCCF_CELL_BYTES     6'd53
`define RXCCF_HDR_BYTES      6'd5
`define RXCCF_MODE_CHG_CTRL  2'b00
`define RXCCF_MODE_ALL_CTRL  2'b01
`define RXCCF_MODE_ALL_CELL  2'b10
`define RXCCF_MODE_NONE      2'b11
`define RXCCF_RESP_OKAY      2'b00
`define RXCCF_RESP_SLVERR    2'b10
`endif

/* File: tb/rxccf_chk_properties.sv */
// concurrent checks on the register bus and readout words of the change fifo block
// assumes it is bound to rxccf_top and sees only that module's ports
`timescale 1ns/1ns
`include "rxccf_consts.vh"
module rxccf_chk #(
    parameter LINKS  = 16,
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire              aclk,
    input wire              aresetn,
    // write channels
    input wire              s_axi_awvalid,
    input wire              s_axi_awready,
    input wire              s_axi_wvalid,
    input wire              s_axi_wready,
    input wire              s_axi_bvalid,
    // read channels
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire [31:0]       s_axi_rdata,
    input wire [1:0]        s_axi_rresp,
    input wire              s_axi_rvalid,
    input wire              s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read data is captured at the address handshake, so the word shows one edge later
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_stat = ar_take && (s_axi_araddr == {`RXCCF_IDX_STATUS, 2'b00});
    wire rd_res  = ar_take && (s_axi_araddr >= {`RXCCF_IDX_RESULT, 2'b00})
                   && (s_axi_araddr <= {`RXCCF_IDX_RESULT_END, 2'b00});
    AST_RVALID_NEXT: assert property (ar_take |=> s_axi_rvalid) else $error("rvalid late");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
    AST_B_TIMING: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("bvalid not two cycles after write");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
    AST_STATUS_ZERO: assert property (rd_stat |=> s_axi_rdata[15:6] == 10'h000) else $error("status high bits");
    AST_STATUS_LEVEL: assert property (rd_stat |=> s_axi_rdata[5:4] == s_axi_rdata[3:2] - s_axi_rdata[1:0])
        else $error("status level mismatch");
    AST_DEBUG_ZERO: assert property (ar_take && s_axi_araddr == {`RXCCF_IDX_DEBUG, 2'b00}
        |=> s_axi_rdata[15:6] == 10'h000) else $error("debug high bits");
    AST_ADVANCE_WO: assert property (ar_take && s_axi_araddr == {`RXCCF_IDX_ADVANCE, 2'b00}
        |=> s_axi_rdata == 32'h0000_0000) else $error("advance strobe read back");
    AST_RESULT_OFS: assert property (rd_res |=> s_axi_rdata[15:0] == `RXCCF_RESULT_RESET
        || (s_axi_rdata[13:8] >= 6'd1 && s_axi_rdata[13:8] <= 6'd53)) else $error("offset out of range");
    AST_UNMAPPED: assert property (ar_take && s_axi_araddr == {ADDR_W{1'b0}}
        |=> s_axi_rresp == `RXCCF_RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
    cover property (rd_stat);
    cover property (rd_res);
    cover property (s_axi_bvalid && s_axi_awready == 1'b0);
endmodule // rxccf_chk

bind rxccf_top rxccf_chk #(.LINKS(LINKS), .ADDR_W(ADDR_W)) rxccf_chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* File: tb/rxccf_top_tb.sv */
// self-checking bench for the change fifo block: register bus tasks and cell stream driver
// assumes the design answers before the watchdog below fires
`timescale 1ns/1ns
`include "rxccf_consts.vh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module rxccf_top_tb;
    logic        aclk = 0, aresetn = 0;
    logic        cell_valid = 0, cell_sop = 0, cell_ctrl = 0;
    logic [3:0]  cell_link = 4'h0;
    logic [7:0]  cell_data = 8'h00;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          miscompares = 0, tests_run = 0;
    logic [31:0] rd;
    logic [1:0]  rs;

    rxccf_top #(.LINKS(16), .ADDR_W(12)) rxccf_top_i (
        .aclk(aclk), .aresetn(aresetn), .cell_valid(cell_valid), .cell_sop(cell_sop), .cell_ctrl(cell_ctrl),
        .cell_link(cell_link), .cell_data(cell_data), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // each channel is released at the edge where it is taken; a hang is left to the watchdog
    task automatic reg_wr(input logic [9:0] idx, input logic [15:0] d, output logic [1:0] resp);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 0;
        // one idle edge so the next call never reassigns bready in this time step
        @(posedge aclk);
    endtask

    task automatic reg_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
        reg_rd(idx, rd, rs);
        `CHK(nm, exp, rd)
    endtask

    // one whole cell, control or not, all bytes zero except offsets 3 and 53
    task automatic send_cell(input logic [3:0] lk, input logic ct, input logic [7:0] b3, input logic [7:0] b53);
        for (int i = 1; i <= 53; i++) begin
            cell_valid <= 1;
            cell_sop <= (i == 1);
            cell_ctrl <= ct;
            cell_link <= lk;
            cell_data <= (i == 3) ? b3 : (i == 53) ? b53 : 8'h00;
            @(posedge aclk);
        end
        cell_valid <= 0;
        cell_sop <= 0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_reset_values;
        rd_chk("result0", `RXCCF_IDX_RESULT, 32'h0000_8000);
        rd_chk("result15", `RXCCF_IDX_RESULT_END, 32'h0000_8000);
        rd_chk("nonempty", `RXCCF_IDX_NONEMPTY, 32'h0);
        rd_chk("status", `RXCCF_IDX_STATUS, 32'h0);
        rd_chk("debug", `RXCCF_IDX_DEBUG, 32'h0);
    endtask

    task automatic t_debug_and_map;
        reg_wr(`RXCCF_IDX_DEBUG, 16'hffff, rs);
        rd_chk("debug_all", `RXCCF_IDX_DEBUG, 32'h0000_003f);
        reg_wr(`RXCCF_IDX_DEBUG, 16'h0000, rs);
        rd_chk("advance_rd", `RXCCF_IDX_ADVANCE, 32'h0);
        reg_rd(10'h000, rd, rs);
        `CHK("unmapped_rresp", `RXCCF_RESP_SLVERR, rs)
        reg_wr(10'h000, 16'h1234, rs);
        `CHK("unmapped_bresp", `RXCCF_RESP_SLVERR, rs)
    endtask

    // nothing may be queued when the cell is not stored or not compared
    task automatic t_no_compare;
        reg_wr(`RXCCF_IDX_TYPE_LO, 16'h0003, rs);
        reg_wr(`RXCCF_IDX_PROC_EN, 16'h0001, rs);
        send_cell(4'h0, 1'b1, 8'h11, 8'h22);
        rd_chk("mode_none", `RXCCF_IDX_NONEMPTY, 32'h0);
        reg_wr(`RXCCF_IDX_TYPE_LO, 16'h0001, rs);
        reg_wr(`RXCCF_IDX_PROC_EN, 16'h0000, rs);
        send_cell(4'h0, 1'b1, 8'h11, 8'h22);
        rd_chk("enable_off", `RXCCF_IDX_NONEMPTY, 32'h0);
    endtask

    task automatic t_change_readout;
        reg_wr(`RXCCF_IDX_PROC_EN, 16'h0001, rs);
        send_cell(4'h0, 1'b1, 8'haa, 8'h55);
        rd_chk("nonempty_set", `RXCCF_IDX_NONEMPTY, 32'h1);
        reg_wr(`RXCCF_IDX_STATUS, 16'h0000, rs);
        rd_chk("status_two", `RXCCF_IDX_STATUS, 32'h28);
        rd_chk("word_first", `RXCCF_IDX_RESULT, 32'h83aa);
        reg_wr(`RXCCF_IDX_ADVANCE, 16'h0001, rs);
        rd_chk("word_last", `RXCCF_IDX_RESULT, 32'h7555);
        rd_chk("status_one", `RXCCF_IDX_STATUS, 32'h19);
        reg_wr(`RXCCF_IDX_ADVANCE, 16'h0001, rs);
        rd_chk("word_empty", `RXCCF_IDX_RESULT, 32'h8000);
        rd_chk("nonempty_clr", `RXCCF_IDX_NONEMPTY, 32'h0);
        reg_wr(`RXCCF_IDX_ADVANCE, 16'hfffe, rs);
        reg_wr(`RXCCF_IDX_ADVANCE, 16'h0001, rs);
        rd_chk("empty_adv", `RXCCF_IDX_STATUS, 32'h0a);
        reg_wr(`RXCCF_IDX_STATUS, 16'h0001, rs);
        rd_chk("select_one", `RXCCF_IDX_STATUS, 32'h00);
        reg_wr(`RXCCF_IDX_STATUS, 16'h0000, rs);
        rd_chk("select_zero", `RXCCF_IDX_STATUS, 32'h0a);
    endtask

    // payload-only span hides the byte 3 change; mode 10 keeps other cells, mode 00 drops them
    task automatic t_span_and_modes;
        reg_wr(`RXCCF_IDX_DEBUG, 16'h0002, rs);
        send_cell(4'h0, 1'b1, 8'h33, 8'h66);
        rd_chk("span_word", `RXCCF_IDX_RESULT, 32'h7566);
        reg_wr(`RXCCF_IDX_ADVANCE, 16'h0001, rs);
        reg_wr(`RXCCF_IDX_DEBUG, 16'h0000, rs);
        reg_wr(`RXCCF_IDX_TYPE_LO, 16'h0008, rs);
        reg_wr(`RXCCF_IDX_PROC_EN, 16'h0003, rs);
        send_cell(4'h1, 1'b0, 8'h44, 8'h00);
        send_cell(4'h0, 1'b0, 8'h77, 8'h00);
        rd_chk("all_cells", `RXCCF_IDX_RESULT + 10'h001, 32'h4344);
        rd_chk("ctrl_only", `RXCCF_IDX_NONEMPTY, 32'h0002);
        reg_wr(`RXCCF_IDX_ADVANCE, 16'h0002, rs);
        rd_chk("all_drained", `RXCCF_IDX_NONEMPTY, 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset_values();
        t_debug_and_map();
        t_no_compare();
        t_change_readout();
        t_span_and_modes();
        final_report();
    end

    // the whole sequence needs well under two thousand cycles
    initial begin
        #50000;
        miscompares++;
        final_report();
    end
endmodule // rxccf_top_tb
